// File: rtl/core_storage_cycle_control.sv
`timescale 1ns/100ps
module core_storage_cycle_control
  import core_storage_pkg::*;
#(
  parameter int          DEPTH   = UNIT_BYTES,
  parameter logic        UNIT_ID = 1'b0
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic              read_call,
  input  wire logic              write_call,
  input  wire cpu_req_t          cpu_req,
  output logic [WORD_W-1:0]      read_data,
  output logic                   ready,
  output logic                   parity_err,
  output logic                   busy,
  output logic                   read_ctl,
  output logic                   write_ctl,
  output drive_t                 drive,
  output plane_pair_t            plane_inhibit
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (DEPTH > UNIT_BYTES || DEPTH < BLOCK_BYTES || (DEPTH % BLOCK_BYTES) != 0) begin : g_chk
    $error("DEPTH must be a multiple of 4096 and at most 32768");
  end

  // Unit select must come from the high address byte
  if (UNIT_SEL_BIT >= BYTE_W) begin : g_chk_sel
    $error("Unit select bit lies outside the high address byte");
  end

  // The cycle counter must reach the last clock and the last tap
  if (CYCLE_CLOCKS > (1 << CNT_W) || TAP_COUNT > (1 << TAP_W)) begin : g_chk_cnt
    $error("Cycle counter or tap number is too narrow");
  end

  // One enable per 4K block, picked by the address bits above it
  if ((1 << (ADDR_W - BLOCK_LSB)) != BLOCK_COUNT ||
      (1 << BLOCK_LSB) != BLOCK_BYTES) begin : g_chk_blk
    $error("Block decode does not match the block size");
  end

  if (XDIR_BIT >= ADDR_W || XSET_BIT >= ADDR_W) begin : g_chk_x
    $error("X direction or X set bit lies outside the address");
  end

  // The array word must be out before the strobe takes it
  if (RD_FETCH_TAP >= RD_STRB_SET) begin : g_chk_fetch
    $error("Fetch tap must come before the strobe tap");
  end

  // Ready must not promise a byte that is not captured yet
  if (RD_READY_TAP <= RD_STRB_SET) begin : g_chk_ready
    $error("Ready tap must follow the strobe tap");
  end

  // Inhibit current has to oppose the whole write drive pulse
  if (WR_INH_SET > WR_DRIVE_SET || WR_INH_RST < WR_DRIVE_RST) begin : g_chk_inh
    $error("Inhibit window must cover the write drive window");
  end

  // The drive and inhibit strobes and the store tap have to fall inside the cycle
  if (RD_DRIVE_RST >= TAP_COUNT || WR_DRIVE_RST >= TAP_COUNT ||
      WR_INH_RST >= TAP_COUNT || WR_STORE_TAP >= TAP_COUNT) begin : g_chk_taps
    $error("A timing tap lies beyond the end of the cycle");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // The processor clock is unrelated, so calls and the held address
  // and data all pass two stages; the third call stage finds edges.
  logic       rcall_s1_r, rcall_s2_r, rcall_s3_r;
  logic       rcall_s1_nxt, rcall_s2_nxt, rcall_s3_nxt;
  logic       wcall_s1_r, wcall_s2_r, wcall_s3_r;
  logic       wcall_s1_nxt, wcall_s2_nxt, wcall_s3_nxt;
  cpu_req_t   req_s1_r, req_s2_r;
  cpu_req_t   req_s1_nxt, req_s2_nxt;

  always_comb begin
    rcall_s1_nxt = read_call;
    rcall_s2_nxt = rcall_s1_r;
    rcall_s3_nxt = rcall_s2_r;
    wcall_s1_nxt = write_call;
    wcall_s2_nxt = wcall_s1_r;
    wcall_s3_nxt = wcall_s2_r;
    req_s1_nxt   = cpu_req;
    req_s2_nxt   = req_s1_r;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rcall_s1_r <= 1'b0;
      rcall_s2_r <= 1'b0;
      rcall_s3_r <= 1'b0;
      wcall_s1_r <= 1'b0;
      wcall_s2_r <= 1'b0;
      wcall_s3_r <= 1'b0;
      req_s1_r   <= '0;
      req_s2_r   <= '0;
    end else begin
      rcall_s1_r <= rcall_s1_nxt;
      rcall_s2_r <= rcall_s2_nxt;
      rcall_s3_r <= rcall_s3_nxt;
      wcall_s1_r <= wcall_s1_nxt;
      wcall_s2_r <= wcall_s2_nxt;
      wcall_s3_r <= wcall_s3_nxt;
      req_s1_r   <= req_s1_nxt;
      req_s2_r   <= req_s2_nxt;
    end
  end

  logic rd_edge;
  logic wr_edge;
  logic unit_sel;

  assign rd_edge  = rcall_s2_r && !rcall_s3_r;
  assign wr_edge  = wcall_s2_r && !wcall_s3_r;
  assign unit_sel = (req_s2_r.addr_hi[UNIT_SEL_BIT] == UNIT_ID);

  // ----------------------------------------------------------------
  // Cycle control latches
  // ----------------------------------------------------------------
  cyc_state_t        state_r, state_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [WORD_W-1:0] wdata_r, wdata_nxt;
  logic              start_rd, start_wr;
  logic              chain_run;
  logic [CNT_W-1:0]  chain_cnt;
  logic [TAP_W-1:0]  chain_tap;
  logic              chain_done;

  // A call seen with both lines rising on the same clock is ambiguous and is dropped
  assign start_rd = (state_r == ST_IDLE) && unit_sel && rd_edge && !wr_edge;
  assign start_wr = (state_r == ST_IDLE) && unit_sel && wr_edge && !rd_edge;

  always_comb begin
    state_nxt = state_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    case (state_r)
      ST_IDLE: begin
        if (start_rd) begin
          state_nxt = ST_READ;
          addr_nxt  = ADDR_W'({req_s2_r.addr_hi, req_s2_r.addr_lo});
        end else if (start_wr) begin
          state_nxt = ST_WRITE;
          addr_nxt  = ADDR_W'({req_s2_r.addr_hi, req_s2_r.addr_lo});
          wdata_nxt = req_s2_r.store_data;
        end
      end
      ST_READ: begin
        // No restore here; the processor must follow with a write
        if (chain_done) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (chain_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      addr_r  <= '0;
      wdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  storage_timing_chain u_chain (
    .ref_clk (ref_clk),
    .reset   (reset),
    .start   (start_rd || start_wr),
    .running (chain_run),
    .cnt     (chain_cnt),
    .tap     (chain_tap),
    .done    (chain_done)
  );

  // ----------------------------------------------------------------
  // Array access
  // ----------------------------------------------------------------
  logic              in_rd, in_wr;
  logic              mem_rd, mem_wr;
  logic [WORD_W-1:0] mem_rdata;

  assign in_rd  = (state_r == ST_READ) && chain_run;
  assign in_wr  = (state_r == ST_WRITE) && chain_run;
  assign mem_rd = in_rd && (chain_cnt == tap_start(RD_FETCH_TAP));
  assign mem_wr = in_wr && (chain_cnt == tap_start(WR_STORE_TAP));

  core_array_mem #(
    .DEPTH (DEPTH),
    .AW    (ADDR_W),
    .DW    (WORD_W)
  ) u_array (
    .ref_clk (ref_clk),
    .rd_en   (mem_rd),
    .wr_en   (mem_wr),
    .addr    (addr_r),
    .wdata   (wdata_r),
    .rdata   (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Read data, ready and check
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] rdata_r, rdata_nxt;
  logic              ready_r, ready_nxt;
  logic              perr_r, perr_nxt;
  logic              strobe_cap;

  assign strobe_cap = in_rd && (chain_cnt == tap_start(RD_STRB_SET));

  always_comb begin
    rdata_nxt = rdata_r;
    perr_nxt  = perr_r;
    if (start_rd) begin
      perr_nxt = 1'b0;
    end
    if (strobe_cap) begin
      rdata_nxt = mem_rdata;
      perr_nxt  = !odd_ok(mem_rdata);
    end
    // Held from the fixed tap until the cycle ends
    ready_nxt = in_rd && !chain_done && (tap_of(chain_cnt + 1'b1) >= RD_READY_TAP);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_r <= '0;
      ready_r <= 1'b0;
      perr_r  <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      perr_r  <= perr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Drive, sense and inhibit strobes
  // ----------------------------------------------------------------
  drive_t      drive_r, drive_nxt;
  plane_pair_t pinh_r, pinh_nxt;
  logic [TAP_W-1:0] ntap;
  logic        nrd, nwr;
  logic        inh_on;
  logic        strb_on;

  // Strobes are registered, so decode the tap of the coming clock
  assign ntap = tap_of(chain_cnt + 1'b1);
  assign nrd  = in_rd && !chain_done;
  assign nwr  = in_wr && !chain_done;

  always_comb begin
    drive_nxt         = '0;
    inh_on            = nwr && in_window(ntap, WR_INH_SET, WR_INH_RST);
    strb_on           = nrd && in_window(ntap, RD_STRB_SET, RD_STRB_RST);
    drive_nxt.x_read  = nrd && in_window(ntap, RD_DRIVE_SET, RD_DRIVE_RST);
    drive_nxt.y_read  = drive_nxt.x_read;
    drive_nxt.x_write = nwr && in_window(ntap, WR_DRIVE_SET, WR_DRIVE_RST);
    drive_nxt.y_write = drive_nxt.x_write;
    drive_nxt.x_dir   = (nrd || nwr) && addr_r[XDIR_BIT];
    drive_nxt.x_set   = (nrd || nwr) && addr_r[XSET_BIT];
    drive_nxt.strobe  = strb_on;
    if (strb_on || inh_on) begin
      drive_nxt.block_en[addr_r[ADDR_W-1:BLOCK_LSB]] = 1'b1;
    end
    drive_nxt.inhibit = inh_on ? ~wdata_r : '0;
    pinh_nxt          = plane_map(drive_nxt.inhibit);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      drive_r <= '0;
      pinh_r  <= '0;
    end else begin
      drive_r <= drive_nxt;
      pinh_r  <= pinh_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign read_data     = rdata_r;
  assign ready         = ready_r;
  assign parity_err    = perr_r;
  assign busy          = (state_r != ST_IDLE);
  assign read_ctl      = (state_r == ST_READ);
  assign write_ctl     = (state_r == ST_WRITE);
  assign drive         = drive_r;
  assign plane_inhibit = pinh_r;

endmodule : core_storage_cycle_control

// File: pkg/core_storage_pkg.sv
// What this block does
// - A read cycle then a write cycle to one location finish within 1.5 us.
// - Each location keeps eight data bits plus one check bit giving odd parity.
// - One unit holds at most 32,768 bytes; two units make 65,536.
// - A read call starts a read cycle and returns the addressed byte.
// - Ready rises once the read byte is valid; processor captures on it.
// - After a read the unit goes idle without restoring; it awaits a write.
// - A write call stores the processor data register at the same address.
// - Own timing generator runs each started cycle to completion unaided.
// - Timing spans 750 ns with 25 ns taps; strobes are tap-set/reset latches.
// - Read call sets read control latch; read cycle lasts 750 ns.
// - Smallest array pairs bits on planes: 0/5, 1/6, 2/7, 3/P, 4 alone.
// - Sensing and inhibit are enabled only for the addressed 4,096-byte block.
// - X current direction follows the address so only one 8K half coincides.
// - Largest array: address picks 16K X set, X winding and its direction.
// - Write call sets write control latch; write cycle lasts 750 ns.
// - Inhibit driver on for each zero data bit, off for each one bit.
// - High address bit selects which unit's timing generator a call starts.
package core_storage_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 10;
  localparam int CYCLE_NS     = 750;
  localparam int TAP_NS       = 25;
  localparam int CYCLE_CLOCKS = CYCLE_NS / CLK_NS;
  localparam int TAP_COUNT    = CYCLE_NS / TAP_NS;
  localparam int CNT_W        = 7;
  localparam int TAP_W        = 5;

  // Read taps
  localparam logic [TAP_W-1:0] RD_DRIVE_SET = 5'h01;
  localparam logic [TAP_W-1:0] RD_DRIVE_RST = 5'h0c;
  localparam logic [TAP_W-1:0] RD_FETCH_TAP = 5'h06;
  localparam logic [TAP_W-1:0] RD_STRB_SET  = 5'h0a;
  localparam logic [TAP_W-1:0] RD_STRB_RST  = 5'h0c;
  localparam logic [TAP_W-1:0] RD_READY_TAP = 5'h0c;
  // Write taps
  localparam logic [TAP_W-1:0] WR_DRIVE_SET = 5'h02;
  localparam logic [TAP_W-1:0] WR_DRIVE_RST = 5'h0e;
  localparam logic [TAP_W-1:0] WR_INH_SET   = 5'h01;
  localparam logic [TAP_W-1:0] WR_INH_RST   = 5'h0f;
  localparam logic [TAP_W-1:0] WR_STORE_TAP = 5'h08;

  // ----------------------------------------------------------------
  // Storage geometry
  // ----------------------------------------------------------------
  localparam int BYTE_W       = 8;
  localparam int WORD_W       = 9;
  localparam int UNIT_BYTES   = 32768;
  localparam int ADDR_W       = 15;
  localparam int BLOCK_BYTES  = 4096;
  localparam int BLOCK_LSB    = 12;
  localparam int BLOCK_COUNT  = 8;
  localparam int XDIR_BIT     = 13;
  localparam int XSET_BIT     = 14;
  localparam int UNIT_SEL_BIT = 7;
  localparam int PLANES       = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [BYTE_W-1:0] addr_hi;
    logic [BYTE_W-1:0] addr_lo;
    logic [WORD_W-1:0] store_data;
  } cpu_req_t;

  typedef struct packed {
    logic                   x_read;
    logic                   y_read;
    logic                   x_write;
    logic                   y_write;
    logic                   x_dir;
    logic                   x_set;
    logic                   strobe;
    logic [BLOCK_COUNT-1:0] block_en;
    logic [WORD_W-1:0]      inhibit;
  } drive_t;

  typedef logic [PLANES-1:0][1:0] plane_pair_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10
  } cyc_state_t;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [TAP_W-1:0] tap_of(input logic [CNT_W-1:0] cnt);
    tap_of = TAP_W'(int'(cnt) * CLK_NS / TAP_NS);
  endfunction : tap_of

  // First clock of a tap, rounded up
  function automatic logic [CNT_W-1:0] tap_start(input logic [TAP_W-1:0] tap);
    tap_start = CNT_W'((int'(tap) * TAP_NS + CLK_NS - 1) / CLK_NS);
  endfunction : tap_start

  function automatic logic in_window(input logic [TAP_W-1:0] tap,
                                     input logic [TAP_W-1:0] set_tap,
                                     input logic [TAP_W-1:0] rst_tap);
    in_window = (tap >= set_tap) && (tap < rst_tap);
  endfunction : in_window

  function automatic logic odd_ok(input logic [WORD_W-1:0] w);
    odd_ok = ^w;
  endfunction : odd_ok

  // Bit 8 is the check bit
  function automatic plane_pair_t plane_map(input logic [WORD_W-1:0] w);
    plane_map[0] = {w[5], w[0]};
    plane_map[1] = {w[6], w[1]};
    plane_map[2] = {w[7], w[2]};
    plane_map[3] = {w[8], w[3]};
    plane_map[4] = {1'b0, w[4]};
  endfunction : plane_map

endpackage : core_storage_pkg

// File: rtl/storage_timing_chain.sv
`timescale 1ns/100ps
module storage_timing_chain
  import core_storage_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             start,
  output logic                  running,
  output logic [CNT_W-1:0]      cnt,
  output logic [TAP_W-1:0]      tap,
  output logic                  done
);

  logic             run_r;
  logic             run_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             last;

  // ----------------------------------------------------------------
  // Free of the processor once started
  // ----------------------------------------------------------------
  assign last = run_r && (cnt_r == CNT_W'(CYCLE_CLOCKS - 1));

  always_comb begin
    run_nxt = run_r;
    cnt_nxt = cnt_r;
    if (run_r) begin
      cnt_nxt = last ? '0 : cnt_r + 1'b1;
      run_nxt = !last;
    end else if (start) begin
      run_nxt = 1'b1;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      run_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      run_r <= run_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign running = run_r;
  assign cnt     = cnt_r;
  assign tap     = tap_of(cnt_r);
  assign done    = last;

endmodule : storage_timing_chain

// File: rtl/core_array_mem.sv
`timescale 1ns/100ps
module core_array_mem #(
  parameter int DEPTH = 32768,
  parameter int AW    = 15,
  parameter int DW    = 9
) (
  input  wire logic          ref_clk,
  input  wire logic          rd_en,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] rdata_r;

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
    if (rd_en) begin
      rdata_r <= mem[addr];
    end
  end

  assign rdata = rdata_r;

endmodule : core_array_mem

// File: bench/core_storage_cycle_control_properties.sv
`timescale 1ns/100ps
module core_storage_cycle_control_properties
  import core_storage_pkg::*;
#(
  parameter int   DEPTH   = UNIT_BYTES,
  parameter logic UNIT_ID = 1'b0
) (
  input wire logic              ref_clk,
  input wire logic              reset,
  input wire logic              read_call,
  input wire logic              write_call,
  input wire cpu_req_t          cpu_req,
  input wire logic [WORD_W-1:0] read_data,
  input wire logic              ready,
  input wire logic              parity_err,
  input wire logic              busy,
  input wire logic              read_ctl,
  input wire logic              write_ctl,
  input wire drive_t            drive,
  input wire plane_pair_t       plane_inhibit
);
  logic [7:0]        run_cnt_r;
  logic [ADDR_W-1:0] addr_q_r;
  logic [WORD_W-1:0] data_q_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Address frozen at the last idle clock; the processor holds it across the take
  always_ff @(posedge ref_clk) begin
    if (reset || !busy) begin
      run_cnt_r <= 8'h00;
      addr_q_r  <= ADDR_W'({cpu_req.addr_hi, cpu_req.addr_lo});
      data_q_r  <= cpu_req.store_data;
    end else begin
      run_cnt_r <= run_cnt_r + 8'h01;
    end
  end

  AST_CYCLE_LEN: assert property ($fell(busy) |-> run_cnt_r == 8'h4b)
    else $error("cycle length is not 75 clocks");
  AST_RUN_BOUND: assert property (busy |-> run_cnt_r < 8'h4b)
    else $error("cycle ran past 75 clocks");
  AST_ONE_LATCH: assert property (busy == (read_ctl ^ write_ctl))
    else $error("control latches not exclusive");
  AST_NO_RETRIGGER: assert property (
      busy && $past(busy) |-> $stable({read_ctl, write_ctl}))
    else $error("control latch changed mid cycle");
  AST_READY_IN_READ: assert property (ready |-> read_ctl)
    else $error("ready outside a read cycle");
  AST_READY_TAP: assert property ($rose(ready) |-> run_cnt_r inside {[29:31]})
    else $error("ready rose away from its tap");
  AST_DATA_STEADY: assert property ($rose(ready) |=> $stable(read_data) [*8])
    else $error("read data moved while ready");
  AST_STROBE_BLOCK: assert property (drive.strobe |->
      read_ctl && drive.block_en == 8'h01 << addr_q_r[14:12])
    else $error("strobe block enable wrong");
  AST_INHIBIT: assert property (write_ctl && |drive.block_en |->
      drive.inhibit == ~data_q_r)
    else $error("inhibit does not follow zero bits");
  AST_XDIR: assert property (drive.x_read || drive.x_write |->
      drive.x_dir == addr_q_r[13] && drive.x_set == addr_q_r[14])
    else $error("x direction or set wrong");
  AST_RD_GATE: assert property (drive.x_read || drive.y_read |-> read_ctl)
    else $error("read drive outside read cycle");
  AST_WR_GATE: assert property (drive.x_write || drive.y_write |-> write_ctl)
    else $error("write drive outside write cycle");
  AST_PLANE: assert property ($stable(drive.inhibit) |->
      plane_inhibit[0] == {drive.inhibit[5], drive.inhibit[0]} &&
      plane_inhibit[3] == {drive.inhibit[8], drive.inhibit[3]} &&
      plane_inhibit[4] == {1'b0, drive.inhibit[4]})
    else $error("plane pairing wrong");

  COV_READ: cover property ($rose(ready));
  COV_WRITE: cover property ($rose(write_ctl));
  COV_PARITY: cover property ($rose(parity_err));
endmodule : core_storage_cycle_control_properties

bind core_storage_cycle_control core_storage_cycle_control_properties #(
  .DEPTH(DEPTH), .UNIT_ID(UNIT_ID)
) props_i (
  .ref_clk(ref_clk), .reset(reset), .read_call(read_call), .write_call(write_call),
  .cpu_req(cpu_req), .read_data(read_data), .ready(ready), .parity_err(parity_err),
  .busy(busy), .read_ctl(read_ctl), .write_ctl(write_ctl), .drive(drive),
  .plane_inhibit(plane_inhibit)
);

// File: bench/cpu_model.sv
`timescale 1ns/100ps
module cpu_model
  import core_storage_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              ready,
  input wire logic              busy,
  input wire logic [WORD_W-1:0] read_data,
  output logic                  read_call,
  output logic                  write_call,
  output cpu_req_t              cpu_req
);
  logic [WORD_W-1:0] data_reg = '0;
  logic              hang     = 1'b0;
  int                len;

  initial begin
    read_call  = 1'b0;
    write_call = 1'b0;
    cpu_req    = '0;
  end

  // Intrude raises the other call mid cycle, which must be ignored
  task automatic cycle(input logic wr, input logic [15:0] a, input logic [8:0] d,
                       input logic intrude, output logic taken);
    int i;
    len = 0;
    @(negedge ref_clk);
    cpu_req = {a, d};
    @(negedge ref_clk);
    if (wr) write_call = 1'b1;
    else read_call = 1'b1;
    for (i = 0; i < 8 && busy !== 1'b1; i++) @(negedge ref_clk);
    taken = (busy === 1'b1);
    read_call  = 1'b0;
    write_call = 1'b0;
    for (i = 0; i < 100 && busy === 1'b1; i++) begin
      len++;
      if (ready === 1'b1) data_reg = read_data;
      if (intrude && i == 10) write_call = ~wr;
      if (intrude && i == 10) read_call = wr;
      if (i == 20) read_call = 1'b0;
      if (i == 20) write_call = 1'b0;
      @(negedge ref_clk);
    end
    if (busy !== 1'b0) hang = 1'b1;
  endtask : cycle
endmodule : cpu_model

// File: bench/core_storage_cycle_control_tb.sv
`timescale 1ns/100ps
module core_storage_cycle_control_tb
  import core_storage_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              reset   = 1'b1;
  logic              read_call, write_call, ready, parity_err, busy, read_ctl, write_ctl;
  cpu_req_t          cpu_req;
  logic [WORD_W-1:0] read_data;
  drive_t            drive;
  plane_pair_t       plane_inhibit;
  int                errors      = 0;
  int                comparisons = 0;

  always #5 ref_clk = ~ref_clk;

  core_storage_cycle_control core_storage_cycle_control_i (
    .ref_clk(ref_clk), .reset(reset), .read_call(read_call), .write_call(write_call),
    .cpu_req(cpu_req), .read_data(read_data), .ready(ready), .parity_err(parity_err),
    .busy(busy), .read_ctl(read_ctl), .write_ctl(write_ctl), .drive(drive),
    .plane_inhibit(plane_inhibit)
  );
  cpu_model cpu_model_i (
    .ref_clk(ref_clk), .ready(ready), .busy(busy), .read_data(read_data),
    .read_call(read_call), .write_call(write_call), .cpu_req(cpu_req)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    if (errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  function automatic logic [8:0] odd_word(input logic [7:0] b);
    odd_word = {~(^b), b};
  endfunction : odd_word

  task automatic op(input logic wr, input logic [15:0] a, input logic [8:0] d,
                    input logic intrude, input logic exp_taken);
    logic taken;
    cpu_model_i.cycle(wr, a, d, intrude, taken);
    if (cpu_model_i.hang) begin
      errors++;
      print_verdict();
    end else begin
      check("taken", 32'(taken), 32'(exp_taken));
      if (exp_taken) check("cycle_len", 32'(cpu_model_i.len), 32'd75);
    end
  endtask : op

  task automatic read_expect(input logic [15:0] a, input logic [8:0] w, input logic perr);
    op(1'b0, a, 9'h000, 1'b0, 1'b1);
    check("read_data", 32'(cpu_model_i.data_reg), 32'(w));
    check("parity_err", 32'(parity_err), 32'(perr));
  endtask : read_expect

  task automatic t_reset();
    check("idle_outputs", 32'({busy, ready, parity_err, read_ctl, write_ctl}), 32'h0);
    check("drive_idle", 32'(drive), 32'h0);
    check("plane_idle", 32'(plane_inhibit), 32'h0);
  endtask : t_reset

  // One location in every 4K block, across both X sets and directions
  task automatic t_blocks();
    logic [15:0] a;
    for (int b = 0; b < 8; b++) begin
      a = {1'b0, 3'(b), 12'h5a3};
      op(1'b1, a, odd_word(8'(b * 8'h25)), 1'b0, 1'b1);
      read_expect(a, odd_word(8'(b * 8'h25)), 1'b0);
    end
  endtask : t_blocks

  // Seed the byte, read it twice, then write back the byte just read and new data
  task automatic t_rmw();
    op(1'b1, 16'h3123, odd_word(8'h00 * 8'h25), 1'b0, 1'b1);
    read_expect(16'h3123, odd_word(8'h00 * 8'h25), 1'b0);
    read_expect(16'h3123, odd_word(8'h00 * 8'h25), 1'b0);
    op(1'b1, 16'h3123, cpu_model_i.data_reg, 1'b0, 1'b1);
    op(1'b1, 16'h3123, odd_word(8'hc3), 1'b0, 1'b1);
    read_expect(16'h3123, odd_word(8'hc3), 1'b0);
  endtask : t_rmw

  task automatic t_parity();
    op(1'b1, 16'h0001, 9'h000, 1'b0, 1'b1);
    read_expect(16'h0001, 9'h000, 1'b1);
    read_expect(16'h3123, odd_word(8'hc3), 1'b0);
  endtask : t_parity

  // A write call inside a read, and a read inside a write, change nothing
  task automatic t_intrude();
    op(1'b0, 16'h3123, 9'h0ff, 1'b1, 1'b1);
    read_expect(16'h3123, odd_word(8'hc3), 1'b0);
    op(1'b1, 16'h7abc, odd_word(8'h7e), 1'b1, 1'b1);
    read_expect(16'h7abc, odd_word(8'h7e), 1'b0);
  endtask : t_intrude

  task automatic t_other_unit();
    op(1'b1, 16'hb123, odd_word(8'h18), 1'b0, 1'b0);
    op(1'b0, 16'h8001, 9'h000, 1'b0, 1'b0);
    read_expect(16'h3123, odd_word(8'hc3), 1'b0);
  endtask : t_other_unit

  initial begin
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    t_reset();
    t_blocks();
    t_rmw();
    t_parity();
    t_intrude();
    t_other_unit();
    print_verdict();
  end
endmodule : core_storage_cycle_control_tb
